/* File: logic/qsr_pkg.sv */
// Shared constants and types of the quad-rate burst SRAM device logic
package qsr_pkg;

   // ----------------------------------------------------------------
   // Geometry and variant defaults
   // ----------------------------------------------------------------
   localparam int LANE_W       = 9;
   localparam int DEF_LANES    = 2;
   localparam int DEF_ADDR_W   = 10;
   localparam bit DEF_LAT_HALF = 1'h0;

   // ----------------------------------------------------------------
   // Burst offsets: low bit picks the beat pair, pairs are +0/+1, +2/+3
   // ----------------------------------------------------------------
   localparam logic PAIR_LO = 1'h0;
   localparam logic PAIR_HI = 1'h1;

   // ----------------------------------------------------------------
   // Power-on timing
   // ----------------------------------------------------------------
   localparam int LOCK_TIME_US      = 20;
   localparam int SYS_CLK_PERIOD_NS = 40;
   localparam int LOCK_CYC          = (LOCK_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1)
                                      / SYS_CLK_PERIOD_NS;
   localparam int LOCK_CNT_W        = $clog2(LOCK_CYC + 1);

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic ODT_RST   = 1'h0;
   localparam logic READY_RST = 1'h0;
   localparam logic SEL_RST   = 1'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {QSR_LATCH, QSR_WAIT, QSR_RUN} qsr_pwr_t;

   typedef struct packed {
      logic rd_n;
      logic wr_n;
   } qsr_sel_t;

   typedef struct packed {
      logic ready;
      logic on_die_termination;
   } qsr_stat_t;

endpackage

/* File: logic/qsr_mem.sv */
// Lane-writable storage array with registered read data
`timescale 1ns/10ps
module qsr_mem #(
   parameter int WORD_W = 36,
   parameter int LANE_W = 9,
   parameter int ADDR_W = 11
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic [WORD_W/LANE_W-1:0]   we_i,
   input  wire logic [ADDR_W-1:0]          waddr_i,
   input  wire logic [WORD_W-1:0]          wdata_i,
   input  wire logic                       re_i,
   input  wire logic [ADDR_W-1:0]          raddr_i,
   output logic      [WORD_W-1:0]          rdata_o
);
   localparam int NLANE = WORD_W / LANE_W;

   logic [WORD_W-1:0] mem_q [0:(1<<ADDR_W)-1];

   // ----------------------------------------------------------------
   // Write port, one enable per lane
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NLANE; i++) begin
         if (we_i[i]) begin
            mem_q[waddr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (re_i) begin
         rdata_o <= mem_q[raddr_i];
      end
   end

endmodule

/* File: logic/qsr_sram.sv */
// Command sampling, burst data paths and power-on control of the SRAM
`timescale 1ns/10ps
// Behaviour
// - Commands sampled only on main clock rise
// - Data beats on both clock rises
// - Write data on cycles t+1, t+2
// - Read select low starts read burst
// - Latency 2.0: beats at t+2, t+3
// - Latency 2.5: beats from t+2 half
// - Second like request is ignored
// - Read select ignored after read cycle
// - Outputs high impedance during power-up
// - High option at power-on enables termination
// - Low option leaves termination off
// - Termination setting fixed after power-on
// - Termination only on data and enables
// - Low or floating option means disabled
// - Burst offsets +0..+3, four beats
// - Read wins over simultaneous write
// - Per-beat byte enables gate lanes
module qsr_sram #(
   parameter int ADDR_W   = qsr_pkg::DEF_ADDR_W,
   parameter int LANES    = qsr_pkg::DEF_LANES,
   parameter bit LAT_HALF = qsr_pkg::DEF_LAT_HALF
) (
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       k_clk_i,
   input  wire qsr_pkg::qsr_sel_t          sel_i,
   input  wire logic [ADDR_W-1:0]          addr_i,
   input  wire logic [LANES*9-1:0]         d_i,
   input  wire logic [LANES-1:0]           byte_write_enable_n_i,
   input  wire logic                       termination_option_input_i,
   output logic      [LANES*9-1:0]         q_o,
   output logic                            q_oe_o,
   output qsr_pkg::qsr_stat_t              stat_o
);
   localparam int DW  = LANES * qsr_pkg::LANE_W;
   localparam int MAW = ADDR_W + 1;

   function automatic logic [MAW-1:0] pair_addr(input logic [ADDR_W-1:0] a,
                                                input logic              hi);
      pair_addr = {a, hi};
   endfunction

   // ----------------------------------------------------------------
   // Power-on control, system clock domain
   // ----------------------------------------------------------------
   logic                            term_s1_q;
   logic                            term_s2_q;
   qsr_pkg::qsr_pwr_t               pwr_q;
   qsr_pkg::qsr_pwr_t               pwr_d;
   logic [qsr_pkg::LOCK_CNT_W-1:0]  lock_cnt_q;
   logic [qsr_pkg::LOCK_CNT_W-1:0]  lock_cnt_d;
   logic                            odt_q;
   logic                            odt_d;
   logic                            ready_q;
   logic                            ready_d;

   wire lock_done = (lock_cnt_q == qsr_pkg::LOCK_CNT_W'(qsr_pkg::LOCK_CYC - 1));

   // No reset: option must be through both stages when latched
   always_ff @(posedge sys_clk_i) begin
      term_s1_q <= termination_option_input_i;
      term_s2_q <= term_s1_q;
   end

   always_comb begin
      pwr_d      = pwr_q;
      lock_cnt_d = lock_cnt_q;
      odt_d      = odt_q;
      ready_d    = ready_q;
      case (pwr_q)
         qsr_pkg::QSR_LATCH: begin
            odt_d = term_s2_q;
            pwr_d = qsr_pkg::QSR_WAIT;
         end
         // Lock wait gives the controller's clock time to settle
         qsr_pkg::QSR_WAIT: begin
            lock_cnt_d = lock_cnt_q + qsr_pkg::LOCK_CNT_W'(1);
            if (lock_done) begin
               ready_d = 1'h1;
               pwr_d   = qsr_pkg::QSR_RUN;
            end
         end
         qsr_pkg::QSR_RUN: begin
            pwr_d = qsr_pkg::QSR_RUN;
         end
         default: begin
            pwr_d = qsr_pkg::QSR_LATCH;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwr_q      <= qsr_pkg::QSR_LATCH;
         lock_cnt_q <= '0;
         odt_q      <= qsr_pkg::ODT_RST;
         ready_q    <= qsr_pkg::READY_RST;
      end else begin
         pwr_q      <= pwr_d;
         lock_cnt_q <= lock_cnt_d;
         odt_q      <= odt_d;
         ready_q    <= ready_d;
      end
   end

   // termination flag serves the data and enable receivers only
   assign stat_o.on_die_termination = odt_q;
   assign stat_o.ready              = ready_q;

   // ----------------------------------------------------------------
   // Command decode, link clock rising edge
   // ----------------------------------------------------------------
   logic              rdy_s1_q;
   logic              rdy_s2_q;
   logic              rd_prev_q;
   logic              wr_prev_q;
   logic              rd1_q, rd2_q, rd3_q;
   logic              wr1_q, wr2_q, wr3_q;
   logic [ADDR_W-1:0] rd_addr_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [ADDR_W-1:0] wr_hold_q;

   wire rd_req = ~sel_i.rd_n;
   wire wr_req = ~sel_i.wr_n;
   // read on low select unless it was low last edge
   wire rd_go  = rdy_s2_q & rd_req & ~rd_prev_q;
   // read select ignored after a read, else read wins
   wire wr_go  = rdy_s2_q & wr_req & ~wr_prev_q & (~rd_req | rd_prev_q);

   // all state moves on link clock rise only; held when stopped
   always_ff @(posedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdy_s1_q  <= qsr_pkg::READY_RST;
         rdy_s2_q  <= qsr_pkg::READY_RST;
         rd_prev_q <= qsr_pkg::SEL_RST;
         wr_prev_q <= qsr_pkg::SEL_RST;
         {rd1_q, rd2_q, rd3_q} <= '0;
         {wr1_q, wr2_q, wr3_q} <= '0;
         rd_addr_q <= '0;
         wr_addr_q <= '0;
         wr_hold_q <= '0;
      end else begin
         rdy_s1_q  <= ready_q;
         rdy_s2_q  <= rdy_s1_q;
         rd_prev_q <= rd_req;
         wr_prev_q <= wr_req;
         {rd1_q, rd2_q, rd3_q} <= {rd_go, rd1_q, rd2_q};
         {wr1_q, wr2_q, wr3_q} <= {wr_go, wr1_q, wr2_q};
         rd_addr_q <= rd_go ? addr_i : rd_addr_q;
         wr_addr_q <= wr_go ? addr_i : wr_addr_q;
         wr_hold_q <= wr2_q ? wr_addr_q : wr_hold_q;
      end
   end

   // ----------------------------------------------------------------
   // Write data capture, both clock rises
   // ----------------------------------------------------------------
   logic [DW-1:0]    dp_q;
   logic [DW-1:0]    dn_q;
   logic [LANES-1:0] bwp_q;
   logic [LANES-1:0] bwn_q;

   // beats and lane enables taken on every rise
   always_ff @(posedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dp_q  <= '0;
         bwp_q <= '1;
      end else begin
         dp_q  <= d_i;
         bwp_q <= byte_write_enable_n_i;
      end
   end

   // Falling edge of the main clock stands in for the complement's rise
   always_ff @(negedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dn_q  <= '0;
         bwn_q <= '1;
      end else begin
         dn_q  <= d_i;
         bwn_q <= byte_write_enable_n_i;
      end
   end

   // ----------------------------------------------------------------
   // Storage, one word holds a beat pair
   // ----------------------------------------------------------------
   wire                 mem_we  = wr2_q | wr3_q;
   wire                 mem_re  = rd1_q | rd2_q;
   wire [MAW-1:0]       w_addr  = wr2_q ? pair_addr(wr_addr_q, qsr_pkg::PAIR_LO)
                                        : pair_addr(wr_hold_q, qsr_pkg::PAIR_HI);
   wire [MAW-1:0]       r_addr  = rd1_q ? pair_addr(rd_addr_q, qsr_pkg::PAIR_LO)
                                        : pair_addr(rd_addr_q, qsr_pkg::PAIR_HI);
   // active-low enables select stored lanes per beat
   wire [2*LANES-1:0]   lane_we = ~{bwn_q, bwp_q} & {(2*LANES){mem_we}};
   wire [2*DW-1:0]      rdata;

   qsr_mem #(
      .WORD_W (2 * DW),
      .LANE_W (qsr_pkg::LANE_W),
      .ADDR_W (MAW)
   ) u_mem (
      .clk_i   (k_clk_i),
      .rst_i   (rst_i),
      .we_i    (lane_we),
      .waddr_i (w_addr),
      .wdata_i ({dn_q, dp_q}),
      .re_i    (mem_re),
      .raddr_i (r_addr),
      .rdata_o (rdata)
   );

   // ----------------------------------------------------------------
   // Read data launch
   // ----------------------------------------------------------------
   logic [DW-1:0] p_q, h_q, n_q, p25_q, n25_q;
   logic          p_oe_q, n_oe_q, p25_oe_q, n25_oe_q;

   wire rd_beat = rd2_q | rd3_q;

   // even beats on rises of t+2 and t+3
   always_ff @(posedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p_q      <= '0;
         h_q      <= '0;
         p_oe_q   <= 1'h0;
         p25_q    <= '0;
         p25_oe_q <= 1'h0;
      end else begin
         p_q      <= rd_beat ? rdata[DW-1:0] : p_q;
         h_q      <= rd_beat ? rdata[2*DW-1:DW] : h_q;
         p_oe_q   <= rd_beat;
         p25_q    <= n_q;
         p25_oe_q <= n_oe_q;
      end
   end

   // half-cycle later copy feeds the 2.5 variant
   always_ff @(negedge k_clk_i or posedge rst_i) begin
      if (rst_i) begin
         n_q      <= '0;
         n_oe_q   <= 1'h0;
         n25_q    <= '0;
         n25_oe_q <= 1'h0;
      end else begin
         n_q      <= h_q;
         n_oe_q   <= p_oe_q;
         n25_q    <= p_q;
         n25_oe_q <= p_oe_q;
      end
   end

   wire [DW-1:0] out_p    = LAT_HALF ? p25_q    : p_q;
   wire [DW-1:0] out_n    = LAT_HALF ? n25_q    : n_q;
   wire          out_p_oe = LAT_HALF ? p25_oe_q : p_oe_q;
   wire          out_n_oe = LAT_HALF ? n25_oe_q : n_oe_q;

   // launch per clock phase, high-Z when idle
   assign q_o    = k_clk_i ? out_p : out_n;
   assign q_oe_o = k_clk_i ? out_p_oe : out_n_oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   rd_launch_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      rd_go |-> ##3 p_oe_q [*2])
      else $error("read beats not launched two cycles after command");

   rd_idle_hiz_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      !$past(rd_go, 3) && !$past(rd_go, 4) |-> !p_oe_q)
      else $error("output enabled with no read in flight");

   rd_twice_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      rd_go |=> !rd_go)
      else $error("back to back read accepted");

   wr_twice_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      wr_go |=> !wr_go)
      else $error("back to back write accepted");

   rd_priority_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      (rd_req && !rd_prev_q && rdy_s2_q) |-> (rd_go && !wr_go))
      else $error("write started together with a read");

   powerup_hiz_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      !rdy_s2_q |-> (!p_oe_q && !rd1_q && !wr1_q))
      else $error("activity before power-up completed");

   wr_burst_addr_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      wr_go |-> ##2 (mem_we && w_addr == {$past(addr_i, 2), qsr_pkg::PAIR_LO})
                ##1 (mem_we && w_addr == {$past(addr_i, 3), qsr_pkg::PAIR_HI}))
      else $error("write burst addresses out of order");

   rd_burst_addr_a: assert property (
      @(posedge k_clk_i) disable iff (rst_i)
      rd_go |=> (mem_re && r_addr == {$past(addr_i), qsr_pkg::PAIR_LO})
                ##1 (mem_re && r_addr == {$past(addr_i, 2), qsr_pkg::PAIR_HI}))
      else $error("read burst addresses out of order");

   odt_frozen_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (pwr_q != qsr_pkg::QSR_LATCH) |=> $stable(odt_q))
      else $error("termination setting changed after power-on");

   odt_latch_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (pwr_q == qsr_pkg::QSR_LATCH) |=> (odt_q == $past(term_s2_q)))
      else $error("termination option not caught at power-on");

endmodule

/* File: bench/qsr_ctl_model.sv */
// Memory controller model: command issue and write bursts on K
`timescale 1ns/10ps
module qsr_ctl_model (
   input  wire logic        k_clk_i,
   output qsr_pkg::qsr_sel_t sel_o,
   output logic [9:0]       addr_o,
   output logic [17:0]      d_o,
   output logic [1:0]       bwn_o
);
   initial begin
      sel_o  = 2'h3;
      addr_o = 10'h000;
      d_o    = 18'h0_0000;
      bwn_o  = 2'h3;
   end

   // command set after a K rise
   task automatic issue(input logic r, input logic w, input logic [9:0] a);
      @(posedge k_clk_i);
      #2;
      sel_o  = {r, w};
      addr_o = (r & w) ? ~addr_o : a;
   endtask

   // beats at t+1 and t+2, then lines toggle
   task automatic burst(input logic [71:0] d, input logic [7:0] bw);
      @(posedge k_clk_i);
      for (int i = 0; i < 4; i++) begin
         if (i % 2 == 0)
            @(negedge k_clk_i);
         else
            @(posedge k_clk_i);
         #2;
         d_o   = d[18*i +: 18];
         bwn_o = bw[2*i +: 2];
      end
      @(negedge k_clk_i);
      #2;
      d_o   = ~d_o;
      bwn_o = ~bwn_o;
   endtask
endmodule

/* File: bench/qsr_sram_tb_top.sv */
// Self-checking bench of the quad-rate SRAM device logic
`timescale 1ns/10ps
module qsr_sram_tb_top;
   localparam logic [71:0] PAT_A = 72'h12_3456_789a_bcde_f012;
   localparam logic [71:0] PAT_B = 72'hfe_dcba_9876_5432_10ab;
   localparam logic [71:0] PAT_C = 72'h5a_a55a_0ff0_c33c_9669;
   logic               sys_clk = 1'b0;
   logic               k_clk = 1'b0;
   logic               k_run = 1'b1;
   logic               rst;
   logic               odt_opt;
   qsr_pkg::qsr_sel_t  sel;
   logic [9:0]         addr;
   logic [17:0]        d;
   logic [1:0]         bwn;
   logic [17:0]        q;
   logic               q_oe;
   logic [17:0]        q_h;
   logic               q_oe_h;
   qsr_pkg::qsr_stat_t stat;
   int                 bad_count = 0;
   int                 n_compared = 0;

   always #20 sys_clk = ~sys_clk;
   // K may be stopped low to exercise clock stop
   // K half period 32 ns, scaled-down rate
   always begin
      #32;
      if (k_run)
         k_clk = ~k_clk;
   end

   qsr_sram #(.ADDR_W(10), .LANES(2), .LAT_HALF(1'b0)) u_qsr_sram (
      .sys_clk_i                  (sys_clk),
      .rst_i                      (rst),
      .k_clk_i                    (k_clk),
      .sel_i                      (sel),
      .addr_i                     (addr),
      .d_i                        (d),
      .byte_write_enable_n_i      (bwn),
      .termination_option_input_i (odt_opt),
      .q_o                        (q),
      .q_oe_o                     (q_oe),
      .stat_o                     (stat)
   );

   // Half-cycle latency variant on the same controller
   qsr_sram #(.ADDR_W(10), .LANES(2), .LAT_HALF(1'b1)) u_qsr_sram_half (
      .sys_clk_i                  (sys_clk),
      .rst_i                      (rst),
      .k_clk_i                    (k_clk),
      .sel_i                      (sel),
      .addr_i                     (addr),
      .d_i                        (d),
      .byte_write_enable_n_i      (bwn),
      .termination_option_input_i (odt_opt),
      .q_o                        (q_h),
      .q_oe_o                     (q_oe_h),
      .stat_o                     ()
   );

   qsr_ctl_model u_qsr_ctl_model (
      .k_clk_i (k_clk),
      .sel_o   (sel),
      .addr_o  (addr),
      .d_o     (d),
      .bwn_o   (bwn)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] n,
                                         input logic [7:0] bw);
      merge = o;
      for (int i = 0; i < 8; i++)
         if (!bw[i])
            merge[9*i +: 9] = n[9*i +: 9];
   endfunction

   task automatic do_rst(input logic opt);
      int n;
      n       = 0;
      odt_opt = opt;
      rst     = 1'b1;
      repeat (20) @(posedge sys_clk);
      #2;
      chk(q_oe, 1'b0);
      chk(q_oe_h, 1'b0);
      rst = 1'b0;
      while (stat.ready !== 1'b1 && n < 700) begin
         @(posedge sys_clk);
         #2;
         n++;
      end
      chk(n >= qsr_pkg::LOCK_CYC, 1'b1);
      chk(stat.ready, 1'b1);
      chk(stat.on_die_termination, opt);
      repeat (3) @(posedge k_clk);
      $display("reset done, option %0b", opt);
   endtask

   task automatic wr(input logic [9:0] a, input logic [71:0] dat, input logic [7:0] bw,
                     input logic r);
      u_qsr_ctl_model.issue(r, 1'b0, a);
      fork
         u_qsr_ctl_model.burst(dat, bw);
      join_none
      repeat (3) u_qsr_ctl_model.issue(1'b1, 1'b1, 10'h000);
   endtask

   task automatic beats(input logic [71:0] exp, input int skip);
      repeat (skip) @(posedge k_clk);
      for (int i = 0; i < 4; i++) begin
         if (i % 2 == 1)
            @(negedge k_clk);
         else if (i > 0)
            @(posedge k_clk);
         #16;
         chk(q_oe, 1'b1);
         chk(q, exp[18*i +: 18]);
         if (i == 0)
            chk(q_oe_h, 1'b0);
         else
            chk(q_h, exp[18*(i-1) +: 18]);
      end
      @(posedge k_clk);
      #16;
      chk(q_oe, 1'b0);
      chk(q_oe_h, 1'b1);
      chk(q_h, exp[54 +: 18]);
      @(negedge k_clk);
      #16;
      chk(q_oe_h, 1'b0);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [71:0] exp, input logic stop);
      u_qsr_ctl_model.issue(1'b0, 1'b1, a);
      u_qsr_ctl_model.issue(1'b1, 1'b1, 10'h000);
      if (stop) begin
         @(negedge k_clk);
         k_run = 1'b0;
         #500;
         k_run = 1'b1;
      end
      beats(exp, 2);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_basic();
      wr(10'h010, PAT_A, 8'h00, 1'b1);
      rd_chk(10'h010, PAT_A, 1'b0);
      $display("basic done");
   endtask

   task automatic t_lanes();
      wr(10'h010, PAT_B, 8'he4, 1'b1);
      rd_chk(10'h010, merge(PAT_A, PAT_B, 8'he4), 1'b0);
      $display("lanes done");
   endtask

   task automatic t_like();
      wr(10'h020, PAT_C, 8'h00, 1'b1);
      u_qsr_ctl_model.issue(1'b1, 1'b0, 10'h030);
      fork
         u_qsr_ctl_model.burst(PAT_A, 8'h00);
      join_none
      // Refused write sends no burst; PAT_A still on the data lines
      u_qsr_ctl_model.issue(1'b1, 1'b0, 10'h020);
      repeat (3) u_qsr_ctl_model.issue(1'b1, 1'b1, 10'h000);
      rd_chk(10'h020, PAT_C, 1'b0);
      rd_chk(10'h030, PAT_A, 1'b0);
      u_qsr_ctl_model.issue(1'b0, 1'b1, 10'h020);
      u_qsr_ctl_model.issue(1'b0, 1'b1, 10'h030);
      u_qsr_ctl_model.issue(1'b1, 1'b1, 10'h000);
      beats(PAT_C, 1);
      $display("like commands done");
   endtask

   task automatic t_mixed();
      wr(10'h020, PAT_B, 8'h00, 1'b0);
      rd_chk(10'h020, PAT_C, 1'b0);
      u_qsr_ctl_model.issue(1'b0, 1'b1, 10'h020);
      wr(10'h040, PAT_B, 8'h00, 1'b0);
      rd_chk(10'h040, PAT_B, 1'b0);
      rd_chk(10'h040, PAT_B, 1'b1);
      $display("mixed done");
   endtask

   task automatic t_term();
      do_rst(1'b1);
      odt_opt = 1'b0;
      repeat (10) @(posedge sys_clk);
      chk(stat.on_die_termination, 1'b1);
      $display("termination done");
   endtask

   initial begin
      rst     = 1'b1;
      odt_opt = 1'b0;
      do_rst(1'b0);
      t_basic();
      t_lanes();
      t_like();
      t_mixed();
      t_term();
      report_and_stop();
   end

   initial begin
      #300_000;
      bad_count++;
      report_and_stop();
   end
endmodule
